/* File: rtl/refcfg_pkg.sv */
// Shared constants of the reference-pulse, datapath and LVDS config block.
// Assumes a 32-bit AXI4-Lite port with one register per aligned word.
package refcfg_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned POS_W  = 16;
   localparam int unsigned WIN_W  = 32;
   localparam int unsigned SMP_W  = 12;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_CTRL   = 10'h080;
   localparam logic [9:0] IDX_POS    = 10'h090;
   localparam logic [9:0] IDX_DPEN   = 10'h100;
   localparam logic [9:0] IDX_CHCFG  = 10'h101;
   localparam logic [9:0] IDX_LVDS   = 10'h106;
   localparam logic [9:0] IDX_MISC   = 10'h108;
   localparam logic [9:0] IDX_SAMPLE = 10'h109;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_PROC_BIT   = 15;
   localparam int unsigned CTRL_SLEEP_BIT  = 13;
   localparam int unsigned CTRL_POSSEL_BIT = 8;
   localparam int unsigned CTRL_ZOOM_BIT   = 4;
   localparam int unsigned CTRL_SEL_LSB    = 0;
   localparam int unsigned CH_MODE_LSB     = 0;
   localparam int unsigned CH_SRCA_LSB     = 4;
   localparam int unsigned CH_SRCB_LSB     = 6;
   localparam int unsigned LV_RES_LSB      = 4;
   localparam int unsigned LV_LSBSYNC_BIT  = 0;
   localparam int unsigned MISC_DUAL_BIT   = 0;
   localparam int unsigned MISC_PERS_BIT   = 1;

   // ----------------------------------------------------------------
   // Reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [15:0] CTRL_RST   = 16'h2000;
   localparam logic [15:0] CTRL_WMASK = 16'hA11F;
   localparam logic [7:0]  DPEN_RST   = 8'h00;
   localparam logic [7:0]  DPEN_WMASK = 8'h01;
   localparam logic [7:0]  CHCFG_RST  = 8'h02;
   localparam logic [7:0]  CH_WMASK   = 8'hF3;
   localparam logic [7:0]  LVDS_RST   = 8'h00;
   localparam logic [7:0]  LV_WMASK   = 8'h71;

   // ----------------------------------------------------------------
   // Encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] SRC_OFF  = 2'h0;
   localparam logic [1:0] SRC_LVDS = 2'h1;
   localparam logic [1:0] SRC_OSC  = 2'h2;
   localparam logic [1:0] SRC_REG  = 2'h3;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : refcfg_pkg

/* File: rtl/refpulse_capture.sv */
// Capture-position status: last edge or accumulated edges.
// Assumes window and edge pulse come from logic on clk.
module refpulse_capture
   import refcfg_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             edgeSeen,
   input  wire logic             zoom,
   input  wire logic             persist,
   input  wire logic [WIN_W-1:0] window,
   output logic      [POS_W-1:0] position
);
   typedef struct packed {
      logic             persistPrev;
      logic [POS_W-1:0] pos;
   } state_s;

   state_s           st_q;
   state_s           st_d;
   logic [POS_W-1:0] pattern;

   // Coarse view takes every other tap, so it spans twice the time
   function automatic logic [POS_W-1:0] coarse(input logic [WIN_W-1:0] w);
      logic [POS_W-1:0] r;
      r = '0;
      for (int i = 0; i < POS_W; i++) begin
         r[i] = w[2*i+1];
      end
      return r;
   endfunction : coarse

   always_comb begin
      st_d = st_q;
      pattern = zoom ? window[23:8] : coarse(window); // [R4]
      st_d.persistPrev = persist;
      if (persist && !st_q.persistPrev) begin
         st_d.pos = edgeSeen ? pattern : '0; // [R7]
      end else if (edgeSeen) begin
         st_d.pos = persist ? (st_q.pos | pattern) : pattern; // [R7]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0; // [R6]
      end else begin
         st_q <= st_d;
      end
   end

   assign position = st_q.pos;

   pos_reset_a: assert property (@(posedge clk) srst |=> position == '0)
      else $error("capture position not zero after reset"); // [R6]
   pers_clear_a: assert property (@(posedge clk) disable iff (srst)
      $rose(persist) && !edgeSeen |=> position == '0)
      else $error("persistence start did not clear status"); // [R7]
   last_edge_a: assert property (@(posedge clk) disable iff (srst)
      edgeSeen && !persist |=> position == $past(pattern))
      else $error("status did not follow last edge"); // [R7]
endmodule : refpulse_capture

/* File: rtl/lane_format.sv */
// Per-channel source select, LVDS word width, sync pick, sample hold.
// Assumes LVDS word and oscillator sample arrive on clk.
module lane_format
   import refcfg_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             run,
   input  wire logic [1:0]       srcA,
   input  wire logic [1:0]       srcB,
   input  wire logic [2:0]       resolution,
   input  wire logic             lsbSync,
   input  wire logic             dualClock,
   input  wire logic             syncNLevel,
   input  wire logic [SMP_W-1:0] lvdsWord,
   input  wire logic [SMP_W-1:0] oscSample,
   input  wire logic [SMP_W-1:0] regSample,
   output logic      [SMP_W-1:0] sampleA,
   output logic      [SMP_W-1:0] sampleB,
   output logic                  syncStrobe,
   output logic                  powerDownA,
   output logic                  powerDownB
);
   typedef struct packed {
      logic             hold;
      logic [SMP_W-1:0] smpA;
      logic [SMP_W-1:0] smpB;
      logic             sync;
      logic             pdA;
      logic             pdB;
   } state_s;

   state_s           st_q;
   state_s           st_d;
   logic [SMP_W-1:0] lw;

   // Narrow words are MSB aligned; unused low bits forced to zero
   function automatic logic [SMP_W-1:0] resMask(input logic [2:0] r);
      case (r)
         3'h0:    return 12'hFFF;
         3'h1:    return 12'hFFE;
         3'h2:    return 12'hFFC;
         3'h3:    return 12'hFF8;
         default: return 12'hFF0;
      endcase
   endfunction : resMask

   function automatic logic [SMP_W-1:0] pick(input logic [1:0] s,
      input logic [SMP_W-1:0] l, input logic [SMP_W-1:0] o,
      input logic [SMP_W-1:0] g);
      case (s)
         SRC_LVDS: return l;
         SRC_OSC:  return o;
         SRC_REG:  return g;
         default:  return '0;
      endcase
   endfunction : pick

   always_comb begin
      st_d = st_q;
      lw = lvdsWord & resMask(resolution); // [R16]
      st_d.pdA = (srcA == SRC_OFF); // [R14]
      st_d.pdB = (srcB == SRC_OFF); // [R14]
      if (!run) begin
         st_d.hold = 1'b0; // [R8]
         st_d.smpA = '0;
         st_d.smpB = '0;
         st_d.sync = 1'b0;
      end else begin
         st_d.sync = lsbSync ? lvdsWord[0] : ~syncNLevel; // [R17]
         if (!dualClock || !st_q.hold) begin
            st_d.smpA = pick(srcA, lw, oscSample, regSample); // [R14]
            st_d.smpB = pick(srcB, lw, oscSample, regSample);
         end
         st_d.hold = dualClock & ~st_q.hold; // [R19]
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q <= '0;
         st_q.pdA <= 1'b1;
         st_q.pdB <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign sampleA    = st_q.smpA;
   assign sampleB    = st_q.smpB;
   assign syncStrobe = st_q.sync;
   assign powerDownA = st_q.pdA;
   assign powerDownB = st_q.pdB;

   hold_two_a: assert property (@(posedge clk) disable iff (srst)
      run && dualClock && st_q.hold |=> sampleA == $past(sampleA))
      else $error("sample not held for second clock"); // [R19]
   src_off_a: assert property (@(posedge clk) disable iff (srst)
      srcA == SRC_OFF |=> powerDownA && sampleA == '0)
      else $error("disabled channel not powered down"); // [R14]
   res_mask_a: assert property (@(posedge clk) disable iff (srst)
      run && !dualClock && srcA == SRC_LVDS && resolution > 3'h3
      |=> sampleA[3:0] == 4'h0)
      else $error("8-bit mode left low bits set"); // [R16]
   lsb_sync_a: assert property (@(posedge clk) disable iff (srst)
      run && lsbSync |=> syncStrobe == $past(lvdsWord[0]))
      else $error("sync not taken from data LSB"); // [R17]
endmodule : lane_format

/* File: rtl/sysref_datapath_lvds_config.sv */
// Register bank for reference-pulse capture, datapath run, channel
// sources and LVDS input format, reached over AXI4-Lite.
// Assumes one clock; the pulse and sync pins are asynchronous.
//
// Summary of operation
// (R1) Receiver sleep resets set; clear wakes receiver
// (R2) Software drops processing before setting sleep
// (R3) Position source select written zero only
// (R4) Zoom refines status and delay step
// (R5) Four-bit field selects capture delay
// (R6) Read-only 16-bit capture position, resets zero
// (R7) Persistence accumulates edges, else last edge
// (R8) Run bit clear holds datapath reset
// (R9) Run set only after full configuration
// (R10) Run rises only with fuses loaded, oscillator off
// (R11) Channel config changed only while stopped
// (R12) No four-bank mode with dual clock
// (R13) Bank mode, dual clock limit converter rate
// (R14) Source field: off, LVDS, oscillator, register
// (R15) Bank mode one, two, four banks
// (R16) Resolution field sets LVDS word width
// (R17) LSB strobe replaces dedicated sync input
// (R18) Processing enable passes pulse edges inward
// (R19) Dual clock holds samples two clocks
// (R20) Reserved bits read zero, do nothing
//
// Chosen here: register access over AXI4-Lite.
module sysref_datapath_lvds_config
   import refcfg_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              srst,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   input  wire logic              refPulsePin,
   input  wire logic [WIN_W-1:0]  edgeWindow,
   input  wire logic              lvdsSyncNPin,
   input  wire logic [SMP_W-1:0]  lvdsWord,
   input  wire logic [SMP_W-1:0]  oscSample,
   output logic                   refpulseReceiverSleep,
   output logic                   positionSourceSelect,
   output logic [4:0]             captureDelayTap,
   output logic                   datapathReset,
   output logic [3:0]             lvdsBankEnable,
   output logic [2:0]             rateLimitClass,
   output logic [SMP_W-1:0]       sampleA,
   output logic [SMP_W-1:0]       sampleB,
   output logic                   syncStrobe,
   output logic                   channelAPowerDown,
   output logic                   channelBPowerDown
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              awRdy;
      logic [ADDR_W-1:0] awAddr;
      logic              wRdy;
      logic [31:0]       wData;
      logic [3:0]        wStrb;
      logic              bValid;
      logic [1:0]        bResp;
      logic              arRdy;
      logic              rValid;
      logic [31:0]       rData;
      logic [1:0]        rResp;
      logic [15:0]       ctrl;
      logic [7:0]        dpEn;
      logic [7:0]        chCfg;
      logic [7:0]        lvdsCfg;
      logic [1:0]        misc;
      logic [SMP_W-1:0]  regSample;
      logic [1:0]        pulseSync;
      logic [1:0]        syncNSync;
      logic              pulsePrev;
      logic              edgeSeen;
      logic [4:0]        delayTap;
      logic              dpReset;
      logic [3:0]        bankEn;
      logic [2:0]        rateClass;
   } state_s;

   state_s           st_q;
   state_s           st_d;
   logic [POS_W-1:0] capturePos;
   logic [32:0]      wrCur;
   logic [32:0]      rdCur;
   logic [31:0]      merged;
   logic [9:0]       wIdx;
   logic             procEn;
   logic             sleepBit;
   logic             zoomBit;
   logic [3:0]       selField;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Returns {hit, data}; reserved bits are never stored, so read zero
   function automatic logic [32:0] regRead(input logic [9:0] idx,
      input state_s s, input logic [POS_W-1:0] pos);
      if (idx == IDX_CTRL) begin
         return {1'b1, 16'h0000, s.ctrl};
      end else if (idx == IDX_POS) begin
         return {1'b1, 16'h0000, pos};
      end else if (idx == IDX_DPEN) begin
         return {1'b1, 24'h000000, s.dpEn};
      end else if (idx == IDX_CHCFG) begin
         return {1'b1, 24'h000000, s.chCfg};
      end else if (idx == IDX_LVDS) begin
         return {1'b1, 24'h000000, s.lvdsCfg};
      end else if (idx == IDX_MISC) begin
         return {1'b1, 30'h00000000, s.misc};
      end else if (idx == IDX_SAMPLE) begin
         return {1'b1, 20'h00000, s.regSample};
      end else begin
         return {1'b0, 32'h00000000};
      end
   endfunction : regRead

   function automatic logic [31:0] byteMerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : byteMerge

   // Reserved mode enables no banks rather than guessing a width
   function automatic logic [3:0] bankMap(input logic [1:0] m);
      case (m)
         2'h0:    return 4'h1;
         2'h1:    return 4'h3;
         2'h2:    return 4'hF;
         default: return 4'h0;
      endcase
   endfunction : bankMap

   assign procEn   = st_q.ctrl[CTRL_PROC_BIT];
   assign sleepBit = st_q.ctrl[CTRL_SLEEP_BIT];
   assign zoomBit  = st_q.ctrl[CTRL_ZOOM_BIT];
   assign selField = st_q.ctrl[CTRL_SEL_LSB +: 4];
   assign wIdx     = st_q.awAddr[ADDR_W-1:2];

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      wrCur = regRead(wIdx, st_q, capturePos);
      rdCur = regRead(araddr[ADDR_W-1:2], st_q, capturePos);
      merged = byteMerge(wrCur[31:0], st_q.wData, st_q.wStrb);

      // Pins cross in two flops before any edge logic sees them
      st_d.pulseSync = {st_q.pulseSync[0], refPulsePin};
      st_d.syncNSync = {st_q.syncNSync[0], lvdsSyncNPin};
      st_d.pulsePrev = st_q.pulseSync[1];
      st_d.edgeSeen  = st_q.pulseSync[1] & ~st_q.pulsePrev
                       & procEn & ~sleepBit; // [R1] [R18]

      // Address and data may arrive in either order
      if (st_q.awRdy && awvalid) begin
         st_d.awRdy  = 1'b0;
         st_d.awAddr = awaddr;
      end
      if (st_q.wRdy && wvalid) begin
         st_d.wRdy  = 1'b0;
         st_d.wData = wdata;
         st_d.wStrb = wstrb;
      end
      if (!st_q.awRdy && !st_q.wRdy && !st_q.bValid) begin
         st_d.awRdy  = 1'b1;
         st_d.wRdy   = 1'b1;
         st_d.bValid = 1'b1;
         st_d.bResp  = wrCur[32] ? RESP_OKAY : RESP_SLVERR;
         if (wIdx == IDX_CTRL) begin
            st_d.ctrl = merged[15:0] & CTRL_WMASK; // [R5] [R20]
         end else if (wIdx == IDX_DPEN) begin
            st_d.dpEn = merged[7:0] & DPEN_WMASK; // [R20]
         end else if (wIdx == IDX_CHCFG) begin
            st_d.chCfg = merged[7:0] & CH_WMASK; // [R20]
         end else if (wIdx == IDX_LVDS) begin
            st_d.lvdsCfg = merged[7:0] & LV_WMASK; // [R20]
         end else if (wIdx == IDX_MISC) begin
            st_d.misc = merged[1:0];
         end else if (wIdx == IDX_SAMPLE) begin
            st_d.regSample = merged[SMP_W-1:0];
         end
      end
      if (st_q.bValid && bready) begin
         st_d.bValid = 1'b0;
      end

      if (st_q.arRdy && arvalid) begin
         st_d.arRdy  = 1'b0;
         st_d.rValid = 1'b1;
         st_d.rData  = rdCur[31:0];
         st_d.rResp  = rdCur[32] ? RESP_OKAY : RESP_SLVERR;
      end
      if (st_q.rValid && rready) begin
         st_d.rValid = 1'b0;
         st_d.arRdy  = 1'b1;
      end

      // Zoom halves the delay step: coarse taps are even fine taps
      st_d.delayTap  = zoomBit ? {1'b0, selField}
                               : {selField, 1'b0}; // [R4] [R5]
      st_d.dpReset   = ~st_q.dpEn[0]; // [R8]
      st_d.bankEn    = bankMap(st_q.chCfg[CH_MODE_LSB +: 2]); // [R15]
      // Rate limit holds whatever the sources are
      st_d.rateClass = {st_q.misc[MISC_DUAL_BIT],
                        st_q.chCfg[CH_MODE_LSB +: 2]}; // [R13]
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st_q          <= '0;
         st_q.awRdy    <= 1'b1;
         st_q.wRdy     <= 1'b1;
         st_q.arRdy    <= 1'b1;
         st_q.ctrl     <= CTRL_RST; // [R1]
         st_q.dpEn     <= DPEN_RST;
         st_q.chCfg    <= CHCFG_RST;
         st_q.lvdsCfg  <= LVDS_RST;
         st_q.dpReset  <= 1'b1;
         st_q.bankEn   <= 4'hF;
         st_q.rateClass <= 3'h2;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   refpulse_capture u_capture (
      .clk      (clk),
      .srst     (srst),
      .edgeSeen (st_q.edgeSeen),
      .zoom     (zoomBit),
      .persist  (st_q.misc[MISC_PERS_BIT]),
      .window   (edgeWindow),
      .position (capturePos)
   );

   lane_format u_lane (
      .clk        (clk),
      .srst       (srst),
      .run        (st_q.dpEn[0]),
      .srcA       (st_q.chCfg[CH_SRCA_LSB +: 2]),
      .srcB       (st_q.chCfg[CH_SRCB_LSB +: 2]),
      .resolution (st_q.lvdsCfg[LV_RES_LSB +: 3]),
      .lsbSync    (st_q.lvdsCfg[LV_LSBSYNC_BIT]),
      .dualClock  (st_q.misc[MISC_DUAL_BIT]),
      .syncNLevel (st_q.syncNSync[1]),
      .lvdsWord   (lvdsWord),
      .oscSample  (oscSample),
      .regSample  (st_q.regSample),
      .sampleA    (sampleA),
      .sampleB    (sampleB),
      .syncStrobe (syncStrobe),
      .powerDownA (channelAPowerDown),
      .powerDownB (channelBPowerDown)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign awready               = st_q.awRdy;
   assign wready                = st_q.wRdy;
   assign bvalid                = st_q.bValid;
   assign bresp                 = st_q.bResp;
   assign arready               = st_q.arRdy;
   assign rvalid                = st_q.rValid;
   assign rdata                 = st_q.rData;
   assign rresp                 = st_q.rResp;
   assign refpulseReceiverSleep = sleepBit;
   assign positionSourceSelect  = st_q.ctrl[CTRL_POSSEL_BIT];
   assign captureDelayTap       = st_q.delayTap;
   assign datapathReset         = st_q.dpReset;
   assign lvdsBankEnable        = st_q.bankEn;
   assign rateLimitClass        = st_q.rateClass;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sleep_reset_a: assert property ($fell(srst) |->
      refpulseReceiverSleep && !st_q.ctrl[CTRL_PROC_BIT])
      else $error("receiver not asleep after reset"); // [R1]
   edge_gate_a: assert property (st_q.edgeSeen |->
      $past(procEn) && !$past(sleepBit))
      else $error("pulse edge passed while gated"); // [R18]
   dp_held_a: assert property (datapathReset && $past(datapathReset)
      |-> sampleA == '0 && sampleB == '0 && !syncStrobe)
      else $error("datapath active while held in reset"); // [R8]
   tap_step_a: assert property (zoomBit && $stable(st_q.ctrl)
      |=> captureDelayTap == {1'b0, $past(selField)})
      else $error("zoomed delay tap wrong"); // [R4]
   bank_map_a: assert property (
      ##1 $past(st_q.chCfg[1:0]) == 2'h2 |-> lvdsBankEnable == 4'hF)
      else $error("four-bank mode not mapped"); // [R15]
   rate_class_a: assert property (##1 rateLimitClass ==
      {$past(st_q.misc[0]), $past(st_q.chCfg[1:0])})
      else $error("rate limit ignores mode settings"); // [R13]
   reserved_rd_a: assert property (rvalid |-> rdata[31:16] == 16'h0000)
      else $error("reserved read bits not zero"); // [R20]
endmodule : sysref_datapath_lvds_config

/* File: sim/tb_sysref_datapath_lvds_config.sv */
// Self-checking bench for the reference-pulse, datapath and LVDS bank.
// Assumes the AXI4-Lite slave answers within the cycle ceiling below.
module tb_sysref_datapath_lvds_config;
   timeunit 1ns;
   timeprecision 1ps;
   import refcfg_pkg::*;
`define CHK(n, e, g) begin nTests++; if ((g) !== (e)) begin fails++; \
   $display("FAIL %s exp %h got %h", n, e, g); end end
   logic              clk = 0, srst = 1, awvalid = 0, wvalid = 0;
   logic              bready = 0, arvalid = 0, rready = 0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [31:0]       wdata = '0, rdv, rdata, r, seed = 32'h0000B13B;
   logic [3:0]        wstrb = 4'hF, banks;
   logic              awready, wready, bvalid, arready, rvalid;
   logic [1:0]        bresp, rresp, rrs, brs;
   logic              refPulsePin = 0, lvdsSyncNPin = 1;
   logic [WIN_W-1:0]  edgeWindow = '0;
   logic [SMP_W-1:0]  lvdsWord = '0, oscSample = '0, regS, sampleA, sampleB;
   logic              sleepQ, dpRst, syncStrobe, pdA, pdB, posSel;
   logic [4:0]        tap;
   logic [2:0]        rateCls, res;
   logic [3:0]        bankTab [4] = '{4'h1, 4'h3, 4'hF, 4'h0};
   int                fails = 0, nTests = 0, cyc = 0;

   sysref_datapath_lvds_config u_sysref_datapath_lvds_config (
      .clk, .srst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
      .rdata, .rresp, .rvalid, .rready, .refPulsePin, .edgeWindow,
      .lvdsSyncNPin, .lvdsWord, .oscSample, .refpulseReceiverSleep(sleepQ),
      .positionSourceSelect(posSel), .captureDelayTap(tap),
      .datapathReset(dpRst),
      .lvdsBankEnable(banks), .rateLimitClass(rateCls), .sampleA, .sampleB,
      .syncStrobe, .channelAPowerDown(pdA), .channelBPowerDown(pdB));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Narrow LVDS words lose their low bits
   function automatic logic [11:0] expS(input int s);
      case (s)
         0: return 12'h000;
         1: return lvdsWord & (res > 3 ? 12'hFF0 : 12'hFFF << res);
         2: return oscSample;
         default: return regS;
      endcase
   endfunction : expS
   task automatic settle;
      repeat (4) @(posedge clk);
   endtask : settle
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic aDone, wDone;
      aDone = 0;
      wDone = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clk);
         if (awready) aDone = 1;
         if (wready) wDone = 1;
         if (aDone) awvalid <= 0;
         if (wDone) wvalid <= 0;
      end while (!(aDone && wDone));
      do @(posedge clk); while (bvalid !== 1'b1);
      brs = bresp;
      bready <= 0;
      @(posedge clk);
   endtask : wr
   task automatic rd(input logic [11:0] a);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rdv = rdata;
      rrs = rresp;
      rready <= 0;
      @(posedge clk);
   endtask : rd
   task automatic rchk(input string n, input logic [11:0] a,
                       input logic [31:0] e);
      rd(a);
      `CHK(n, e, rdv)
   endtask : rchk
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // Clock, hang guard, sequence
   // ----------------------------------------------------------------
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         fails++;
         stop_test;
      end
   end
   initial begin
      repeat (2) @(posedge clk);
      srst <= 0;
      @(posedge clk);
      `CHK("sleep", 1'b1, sleepQ)
      `CHK("dpReset", 1'b1, dpRst)
      rchk("ctrl", 12'h200, 32'h2000);
      rchk("pos", 12'h240, 32'h0);
      rchk("dpEn", 12'h400, 32'h0);
      rchk("chCfg", 12'h404, 32'h2);
      rchk("lvCfg", 12'h418, 32'h0);
      rd(12'h7FC);
      `CHK("unmapped", RESP_SLVERR, rrs)
      wr(12'h7FC, 32'hFFFFFFFF);
      `CHK("wrUnmapped", RESP_SLVERR, brs)
      $display("test reset done");
      wr(12'h200, 32'hFFFF7EE5);
      rchk("ctrlMask", 12'h200, 32'h2005);
      settle;
      `CHK("tapWide", 5'h0A, tap)
      wr(12'h200, 32'h00000019);
      settle;
      `CHK("tapZoom", 5'h09, tap)
      `CHK("awake", 1'b0, sleepQ)
      `CHK("posSel", 1'b0, posSel)
      for (int m = 0; m < 4; m++) begin
         wr(12'h404, 32'(m));
         settle;
         `CHK("banks", bankTab[m], banks)
         `CHK("rate", {1'b0, 2'(m)}, rateCls)
      end
      wr(12'h420, 32'h1);
      settle;
      `CHK("rateDual", 3'h7, rateCls)
      wr(12'h420, 32'h0);
      $display("test config done");
      regS = 12'(rnd());
      wr(12'h424, {20'h0, regS});
      for (int s = 0; s < 4; s++) begin
         r = rnd();
         res = (s == 1) ? 3'h5 : r[14:12];
         lvdsWord <= r[11:0];
         oscSample <= r[27:16];
         wr(12'h418, {25'h0, res, 4'h0});
         wr(12'h404, {24'h0, 2'(3 - s), 2'(s), 4'h0});
         wr(12'h420, 32'(s > 1));
         wr(12'h400, 32'h1);
         settle;
         `CHK("dpRun", 1'b0, dpRst)
         `CHK("pdA", s == 0, pdA)
         `CHK("pdB", s == 3, pdB)
         `CHK("sampleA", expS(s), sampleA)
         `CHK("sampleB", expS(3 - s), sampleB)
         wr(12'h400, 32'h0);
         settle;
         `CHK("stopped", 12'h000, sampleA)
      end
      $display("test sources done");
      wr(12'h400, 32'h1);
      wr(12'h418, 32'h1);
      lvdsWord <= 12'h001;
      settle;
      `CHK("lsbSync", 1'b1, syncStrobe)
      lvdsWord <= 12'h000;
      settle;
      `CHK("lsbSync0", 1'b0, syncStrobe)
      wr(12'h418, 32'h0);
      lvdsSyncNPin <= 0;
      repeat (2) settle;
      `CHK("pinSync", 1'b1, syncStrobe)
      wr(12'h200, 32'h00008010);
      edgeWindow <= rnd();
      refPulsePin <= 1;
      repeat (2) settle;
      rchk("capture", 12'h240, {16'h0, edgeWindow[23:8]});
      refPulsePin <= 0;
      wr(12'h420, 32'h3);
      edgeWindow <= rnd();
      refPulsePin <= 1;
      repeat (2) settle;
      r = edgeWindow;
      refPulsePin <= 0;
      edgeWindow <= rnd();
      settle;
      refPulsePin <= 1;
      repeat (2) settle;
      rchk("persist", 12'h240, {16'h0, r[23:8] | edgeWindow[23:8]});
      $display("test pins done");
      stop_test;
   end
endmodule : tb_sysref_datapath_lvds_config
